// *** logic/ir_carrier_generator.sv ***
// Overview of operation
// - gate one: pin carries the carrier
// - gate zero: pin held low
// - timer match copies buffer into gate
// - high carrier pulse finishes before gating
// - gate zero halts carrier counter unless the timer clocks from the carrier
// - timer clock from carrier keeps running
// - suppress bit blocks carrier from pin
// - direct gate set may shorten pulse
// - buffered gate load delays by low on shared timer clock
// - high phase lasts modulo plus one
// - low phase lasts modulo plus one
// - low modulo register at 03h
// - suppressed pin stays constant high
// - two-bit source clock select at 13h
// - modulo registers via put and get
module ir_carrier_generator (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [5:0] rf_addr,
  input wire logic rf_wr,
  input wire logic [3:0] rf_wdata,
  output logic [3:0] rf_rdata,
  input wire logic [3:0] pr_addr,
  input wire logic pr_put,
  input wire logic [7:0] transfer_buffer_in,
  output logic [7:0] transfer_buffer_out,
  input wire logic timer_match,
  input wire logic [1:0] timer_clk_sel,
  output logic timer_carrier_clk,
  output logic remote_output_pin
);
  // ==========================================
  // register file
  logic gate_q, gate_d, gate_buffer_q, gate_buffer_d;
  logic suppress_q, suppress_d;
  logic [1:0] clk_sel_q, clk_sel_d;
  logic [7:0] low_mod_q, low_mod_d, high_mod_q, high_mod_d;
  logic direct_set;
  logic gate_rise;
  logic sw_gate_hit;
  always_comb begin
    gate_d = gate_q;
    gate_buffer_d = gate_buffer_q;
    suppress_d = suppress_q;
    clk_sel_d = clk_sel_q;
    low_mod_d = low_mod_q;
    high_mod_d = high_mod_q;
    sw_gate_hit = rf_wr && rf_addr == ir_carrier_pkg::rf_addr_gate;
    if (sw_gate_hit) begin
      gate_d = rf_wdata[ir_carrier_pkg::gate_bit];
      gate_buffer_d = rf_wdata[ir_carrier_pkg::gate_buffer_bit];
    end
    if (rf_wr && rf_addr == ir_carrier_pkg::rf_addr_suppress) begin
      suppress_d = rf_wdata[ir_carrier_pkg::suppress_bit];
    end
    if (rf_wr && rf_addr == ir_carrier_pkg::rf_addr_clk_sel) begin
      clk_sel_d = rf_wdata[1:0];
    end
    // timer copy wins over a same-cycle software write of the gate
    if (timer_match) begin
      gate_d = gate_buffer_q;
    end
    if (pr_put && pr_addr == ir_carrier_pkg::pr_addr_low_modulo) begin
      low_mod_d = transfer_buffer_in;
    end
    if (pr_put && pr_addr == ir_carrier_pkg::pr_addr_high_modulo) begin
      high_mod_d = transfer_buffer_in;
    end
  end
  assign direct_set = sw_gate_hit && !timer_match;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_q <= 1'b0;
      gate_buffer_q <= 1'b0;
      suppress_q <= 1'b0;
      clk_sel_q <= ir_carrier_pkg::clk_sel_half;
      low_mod_q <= 8'h00;
      high_mod_q <= 8'h00;
    end else begin
      gate_q <= gate_d;
      gate_buffer_q <= gate_buffer_d;
      suppress_q <= suppress_d;
      clk_sel_q <= clk_sel_d;
      low_mod_q <= low_mod_d;
      high_mod_q <= high_mod_d;
    end
  end
  // get transfer of the modulo registers, register file read
  always_comb begin
    transfer_buffer_out = 8'h00;
    if (pr_addr == ir_carrier_pkg::pr_addr_low_modulo) begin
      transfer_buffer_out = low_mod_q;
    end else if (pr_addr == ir_carrier_pkg::pr_addr_high_modulo) begin
      transfer_buffer_out = high_mod_q;
    end
    rf_rdata = 4'h0;
    unique case (rf_addr)
      ir_carrier_pkg::rf_addr_gate: begin
        rf_rdata[ir_carrier_pkg::gate_bit] = gate_q;
        rf_rdata[ir_carrier_pkg::gate_buffer_bit] = gate_buffer_q;
      end
      ir_carrier_pkg::rf_addr_suppress:
        rf_rdata[ir_carrier_pkg::suppress_bit] = suppress_q;
      ir_carrier_pkg::rf_addr_clk_sel: rf_rdata[1:0] = clk_sel_q;
      default: rf_rdata = 4'h0;
    endcase
  end
  // ==========================================
  // carrier counter
  carrier_tick_if tk();
  assign tk.sel = clk_sel_q;
  carrier_tick_gen u_tick (.clk(clk), .arst_n(arst_n), .t(tk));
  ir_carrier_pkg::phase_type phase_q, phase_d;
  logic [7:0] cnt_q, cnt_d;
  logic gate_prev_q, gate_prev_d;
  logic out_gate_q, out_gate_d;
  logic timer_uses_carrier;
  logic run;
  logic [7:0] limit;
  assign timer_uses_carrier =
    timer_clk_sel == ir_carrier_pkg::timer_sel_carrier;
  assign gate_rise = gate_q && !gate_prev_q;
  assign tk.restart = gate_rise && !timer_uses_carrier;
  // carrier keeps running while the timer counts from it, and until
  // the last high pulse has left the pin, or that pulse would be clipped
  assign run = gate_q || out_gate_q || timer_uses_carrier;
  assign limit = (phase_q == ir_carrier_pkg::phase_high) ?
    high_mod_q : low_mod_q;
  always_comb begin
    gate_prev_d = gate_q;
    phase_d = phase_q;
    cnt_d = cnt_q;
    if (gate_rise && !timer_uses_carrier) begin
      phase_d = ir_carrier_pkg::phase_high;
      cnt_d = 8'h00;
    end else if (!run) begin
      phase_d = ir_carrier_pkg::phase_low;
      cnt_d = 8'h00;
    end else if (tk.tick) begin
      if (cnt_q == limit) begin
        cnt_d = 8'h00;
        phase_d = (phase_q == ir_carrier_pkg::phase_high) ?
          ir_carrier_pkg::phase_low : ir_carrier_pkg::phase_high;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_prev_q <= 1'b0;
      phase_q <= ir_carrier_pkg::phase_low;
      cnt_q <= 8'h00;
    end else begin
      gate_prev_q <= gate_prev_d;
      phase_q <= phase_d;
      cnt_q <= cnt_d;
    end
  end
  // ==========================================
  // output gating
  logic carrier_hi;
  logic wait_low_q, wait_low_d;
  logic pin_q, pin_d;
  logic tc_q, tc_d;
  assign carrier_hi = phase_q == ir_carrier_pkg::phase_high;
  always_comb begin
    out_gate_d = out_gate_q;
    wait_low_d = wait_low_q;
    if (gate_q != out_gate_q) begin
      // the last high pulse is never cut short
      if (out_gate_q && carrier_hi) begin
        wait_low_d = 1'b1;
      end else begin
        out_gate_d = gate_q;
        wait_low_d = 1'b0;
      end
    end else begin
      wait_low_d = 1'b0;
    end
    // with a shared timer clock a buffered load waits for low
    // a direct write lands mid-phase and may clip the first pulse
    if (timer_uses_carrier && !out_gate_q && gate_q && carrier_hi &&
        !direct_set) begin
      out_gate_d = 1'b0;
    end
    if (suppress_q) begin
      pin_d = 1'b1;
    end else if (out_gate_q) begin
      pin_d = carrier_hi;
    end else begin
      pin_d = 1'b0;
    end
    tc_d = carrier_hi;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_gate_q <= 1'b0;
      wait_low_q <= 1'b0;
      pin_q <= 1'b0;
      tc_q <= 1'b0;
    end else begin
      out_gate_q <= out_gate_d;
      wait_low_q <= wait_low_d;
      pin_q <= pin_d;
      tc_q <= tc_d;
    end
  end
  assign remote_output_pin = pin_q;
  assign timer_carrier_clk = tc_q;
  // ==========================================
  // assertions
  property p_low_when_off;
    @(posedge clk) disable iff (!arst_n)
      (!out_gate_q && !suppress_q) |=> !remote_output_pin;
  endproperty
  a_low_when_off: assert property (p_low_when_off)
    else $error("pin not low with gate off");
  property p_follow;
    @(posedge clk) disable iff (!arst_n)
      (out_gate_q && !suppress_q) |=> remote_output_pin == $past(carrier_hi);
  endproperty
  a_follow: assert property (p_follow)
    else $error("pin not following carrier");
  property p_copy;
    @(posedge clk) disable iff (!arst_n)
      timer_match |=> gate_q == $past(gate_buffer_q);
  endproperty
  a_copy: assert property (p_copy)
    else $error("gate not loaded from buffer");
  property p_hold_high;
    @(posedge clk) disable iff (!arst_n)
      (out_gate_q && carrier_hi) |=> out_gate_q;
  endproperty
  a_hold_high: assert property (p_hold_high)
    else $error("high pulse cut short");
  property p_halt;
    @(posedge clk) disable iff (!arst_n)
      (!run && !gate_rise) |=> cnt_q == 8'h00;
  endproperty
  a_halt: assert property (p_halt)
    else $error("counter ran while halted");
  property p_suppress;
    @(posedge clk) disable iff (!arst_n)
      suppress_q |=> remote_output_pin;
  endproperty
  a_suppress: assert property (p_suppress)
    else $error("suppressed pin not high");
  property p_phase_len;
    @(posedge clk) disable iff (!arst_n)
      (run && tk.tick && cnt_q == limit && !gate_rise) |=>
        phase_q != $past(phase_q);
  endproperty
  a_phase_len: assert property (p_phase_len)
    else $error("phase did not end at modulo");
  property p_restart;
    @(posedge clk) disable iff (!arst_n)
      (gate_rise && !timer_uses_carrier) |=>
        phase_q == ir_carrier_pkg::phase_high && cnt_q == 8'h00;
  endproperty
  a_restart: assert property (p_restart)
    else $error("no restart on gate rise");
  c_carrier: cover property (@(posedge clk) out_gate_q && carrier_hi);
  c_wait: cover property (@(posedge clk) wait_low_q);
  c_suppress: cover property (@(posedge clk) suppress_q && gate_q);
endmodule

// *** logic/ir_carrier_pkg.sv ***
package ir_carrier_pkg;
  // ==========================================
  // register file addresses and bit positions
  localparam logic [5:0] rf_addr_gate = 6'h11;
  localparam logic [5:0] rf_addr_suppress = 6'h12;
  localparam logic [5:0] rf_addr_clk_sel = 6'h13;
  localparam int gate_bit = 0;
  localparam int gate_buffer_bit = 1;
  localparam int suppress_bit = 1;
  // ==========================================
  // peripheral register addresses
  localparam logic [3:0] pr_addr_low_modulo = 4'h3;
  localparam logic [3:0] pr_addr_high_modulo = 4'h4;
  // ==========================================
  // carrier source clock choices, and the timer select for the carrier
  localparam logic [1:0] clk_sel_half = 2'h0;
  localparam logic [1:0] clk_sel_base = 2'h1;
  localparam logic [1:0] clk_sel_double = 2'h2;
  localparam logic [1:0] timer_sel_carrier = 2'h3;
  typedef enum logic [0:0] {phase_high, phase_low} phase_type;
endpackage

// *** logic/carrier_tick_if.sv ***
interface carrier_tick_if;
  logic [1:0] sel;
  logic restart;
  logic tick;
  modport src (input sel, input restart, output tick);
  modport dst (output sel, output restart, input tick);
endinterface

// *** logic/carrier_tick_gen.sv ***
// ==========================================
// source clock tick: half, full or double rate
module carrier_tick_gen (
  input wire logic clk,
  input wire logic arst_n,
  carrier_tick_if.src t
);
  logic [1:0] div_q, div_d;
  // divider restarts with the carrier so the first phase is never short
  always_comb begin
    div_d = t.restart ? 2'h0 : div_q + 2'h1;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_d;
    end
  end
  // clk stands for twice the system clock: double steps every clk,
  // base every second clk, half every fourth
  always_comb begin
    unique case (t.sel)
      ir_carrier_pkg::clk_sel_half: t.tick = &div_q;
      ir_carrier_pkg::clk_sel_base: t.tick = div_q[0];
      default: t.tick = 1'b1;
    endcase
  end
endmodule

// *** bench/ir_led_model.sv ***
// ==========================================
// led driver stage: measures run lengths on the pin
module ir_led_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic led_drive,
  output int hi_len,
  output int lo_len,
  output int rises
);
  timeunit 1ns;
  timeprecision 1ps;
  int run_q;
  logic last_q;
  // lengths counted in clk edges, so rate scaling is the bench's job
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run_q <= 0;
      last_q <= 1'b0;
      hi_len <= 0;
      lo_len <= 0;
      rises <= 0;
    end else begin
      if (led_drive !== last_q) begin
        if (last_q === 1'b1) hi_len <= run_q;
        else lo_len <= run_q;
        if (led_drive === 1'b1) rises <= rises + 1;
        run_q <= 1;
      end else begin
        run_q <= run_q + 1;
      end
      last_q <= led_drive;
    end
  end
endmodule

// *** bench/ir_carrier_generator_tb_top.sv ***
module ir_carrier_generator_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, arst_n, rf_wr, pr_put, timer_match, tclk, pin, last;
  logic [5:0] rf_addr;
  logic [3:0] rf_wdata, rf_rdata, pr_addr;
  logic [7:0] tb_in, tb_out;
  logic [1:0] tsel;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  int hi_len, lo_len, rises, k, r, t0;
  ir_carrier_generator uut (.clk(clk), .arst_n(arst_n), .rf_addr(rf_addr),
    .rf_wr(rf_wr), .rf_wdata(rf_wdata), .rf_rdata(rf_rdata),
    .pr_addr(pr_addr), .pr_put(pr_put), .transfer_buffer_in(tb_in),
    .transfer_buffer_out(tb_out), .timer_match(timer_match),
    .timer_clk_sel(tsel), .timer_carrier_clk(tclk),
    .remote_output_pin(pin));
  ir_led_model led (.clk(clk), .arst_n(arst_n), .led_drive(pin),
    .hi_len(hi_len), .lo_len(lo_len), .rises(rises));
  // ==========================================
  // clock, timeout and shared tasks
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // the whole sequence needs about 1000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rf_put(input logic [5:0] a, input logic [3:0] d);
    @(posedge clk);
    rf_addr <= a;
    rf_wdata <= d;
    rf_wr <= 1'b1;
    @(posedge clk);
    rf_wr <= 1'b0;
  endtask
  task automatic rf_chk(input logic [5:0] a, input logic [3:0] e);
    @(posedge clk);
    rf_addr <= a;
    @(posedge clk);
    #1 check({4'h0, rf_rdata}, {4'h0, e});
  endtask
  task automatic pr_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    pr_addr <= a;
    tb_in <= d;
    pr_put <= 1'b1;
    @(posedge clk);
    pr_put <= 1'b0;
  endtask
  task automatic pr_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    pr_addr <= a;
    @(posedge clk);
    #1 check(tb_out, e);
  endtask
  task automatic count_tc(output int n);
    n = 0;
    last = tclk;
    repeat (40) begin
      @(posedge clk);
      #1;
      if (tclk !== last) n++;
      last = tclk;
    end
  endtask
  task automatic match_pulse();
    @(posedge clk);
    timer_match <= 1'b1;
    @(posedge clk);
    timer_match <= 1'b0;
  endtask
  // ==========================================
  // main sequence
  initial begin
    {arst_n, rf_wr, pr_put, timer_match} = 4'h0;
    {rf_addr, rf_wdata, pr_addr, tb_in, tsel} = 24'h0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    rf_chk(6'h11, 4'h0);
    check({7'h0, pin}, 8'h00);
    pr_wr(4'h3, 8'h5a);
    pr_wr(4'h4, 8'ha5);
    pr_chk(4'h3, 8'h5a);
    pr_chk(4'h4, 8'ha5);
    // clk stands for twice the system clock: half, base and double
    // rates step every 4, 2 and 1 clk
    for (int s = 0; s < 3; s++) begin
      k = (s == 0) ? 4 : ((s == 1) ? 2 : 1);
      rf_put(6'h13, 4'(s));
      rf_chk(6'h13, 4'(s));
      pr_wr(4'h4, 8'h05);
      pr_wr(4'h3, 8'h06);
      rf_put(6'h11, 4'h1);
      repeat (120) @(posedge clk);
      check(8'(hi_len), 8'(6 * k));
      check(8'(lo_len), 8'(7 * k));
      t0 = 0;
      while (pin !== 1'b1 && t0 < 60) begin
        @(posedge clk);
        #1;
        t0++;
      end
      rf_put(6'h11, 4'h0);
      repeat (40) @(posedge clk);
      check(8'(hi_len), 8'(6 * k));
      check({7'h0, pin}, 8'h00);
      r = rises;
      count_tc(t0);
      check(8'(rises), 8'(r));
      check(8'(t0), 8'h00);
    end
    rf_put(6'h11, 4'h2);
    match_pulse();
    repeat (20) @(posedge clk);
    rf_chk(6'h11, 4'h3);
    repeat (60) @(posedge clk);
    check(8'(hi_len), 8'h06);
    rf_put(6'h11, 4'h1);
    match_pulse();
    repeat (20) @(posedge clk);
    rf_chk(6'h11, 4'h0);
    @(posedge clk);
    tsel <= 2'h3;
    count_tc(r);
    check(8'(r > 0), 8'h01);
    rf_put(6'h12, 4'h2);
    rf_put(6'h11, 4'h1);
    repeat (20) @(posedge clk);
    check({7'h0, pin}, 8'h01);
    r = rises;
    repeat (40) @(posedge clk);
    check(8'(rises), 8'(r));
    close_out();
  end
endmodule
